// file: design/tces_pkg.sv
// package: register map, field positions, timing and carrier types of the timer front-end controller
`default_nettype none
package tces_pkg;
	// ----------------------------------------
	// register addresses in the device
	// ----------------------------------------
	localparam logic [15:0] ADDR_PORT2_DIR   = 16'hFF22;
	localparam logic [15:0] ADDR_CLK_EDGE    = 16'hFF61;
	localparam logic [15:0] ADDR_PORT2_ANA   = 16'hFF84;
	localparam logic [15:0] ADDR_OUT_CTRL    = 16'hFF63;
	localparam logic [15:0] ADDR_MODE_CTRL   = 16'hFF66;
	localparam logic [15:0] ADDR_PORT2_LATCH = 16'hFF02;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_DIR      = 8'hFF;
	localparam logic [7:0] RST_ANA      = 8'h00;
	localparam logic [7:0] RST_LATCH    = 8'h00;
	localparam logic [7:0] RST_CLK_EDGE = 8'h00;
	localparam logic [7:0] RST_OUT_CTRL = 8'h00;
	localparam logic [7:0] MODE_STOP    = 8'h00;
	// ----------------------------------------
	// field positions and codes
	// ----------------------------------------
	localparam int unsigned TOC_TRIG    = 6;
	localparam int unsigned TOC_OSPE    = 5;
	localparam int unsigned TOC_SET     = 3;
	localparam int unsigned TOC_CLR     = 2;
	localparam int unsigned TOC_OE      = 0;
	localparam int unsigned IN1_ES_LSB  = 6;
	localparam int unsigned IN0_ES_LSB  = 4;
	localparam int unsigned CLKSEL_LSB  = 0;
	localparam int unsigned MODE_CS_LSB = 2;
	localparam int unsigned PIN0        = 0;
	localparam int unsigned PIN1        = 1;
	localparam logic [7:0]  PRM_RSVD    = 8'h0C;
	localparam logic [1:0]  EDGE_PROHIB = 2'h2;
	localparam logic [1:0]  CLKSEL_IN0  = 2'h3;
	localparam logic [1:0]  MODE_CS_EDGE = 2'h2;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned FXP_HZ          = 10_000_000;
	localparam int unsigned FXP_CYC         = CLK_HZ / FXP_HZ;
	localparam int unsigned DIV_SEL1        = 4;
	localparam int unsigned DIV_SEL2        = 256;
	localparam int unsigned GAP_PERIODS     = 2;
	localparam int unsigned EXT_MIN_PERIODS = 2;
	localparam int unsigned PULSE_MIN_CYC   = EXT_MIN_PERIODS * FXP_CYC + 1;
	// ----------------------------------------
	// carrier types
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_CFG_IN, OP_CFG_OUT, OP_SET_CLK, OP_START, OP_STOP, OP_OUT_CTL, OP_TRIGGER, OP_CHECK
	} tces_op_e;
	typedef struct packed {
		tces_op_e    op;
		logic [7:0]  data;
	} tces_cmd_s;
	typedef struct packed {
		logic        done;
		logic        err;
		logic [7:0]  rdata;
	} tces_rsp_s;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} tces_bus_s;
endpackage : tces_pkg
`default_nettype wire

// file: design/tces_host.sv
// controller that sets up the timer front end of the device and drives its input pins
// What this block does
// - stop timer before non-trigger output-control writes
// - trigger only in one-shot output mode
// - space triggers two count clocks apart
// - write enable and requests in one byte
// - external clock pulses exceed two peripheral periods
// - write clock/edge register only when stopped
// - no input 0 clear-start with edge clock
// - shared pin is input or output, never both
// - timer output needs direction, latch, analog zero
// - timer inputs need direction one, analog zero
`default_nettype none
module tces_host #(
	parameter int unsigned PULSE_W = 16
) (
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic               cmd_valid,
	input  wire tces_pkg::tces_cmd_s cmd,
	output logic                    cmd_ready,
	output tces_pkg::tces_rsp_s     rsp,
	output tces_pkg::tces_bus_s     dev_bus,
	input  wire logic [7:0]         dev_rdata,
	input  wire logic [1:0]         pulse_en,
	input  wire logic [PULSE_W-1:0] pulse_half,
	output logic                    timer_input0,
	output logic                    timer_input1,
	input  wire logic               timer_output_pin,
	output logic                    out_level,
	output logic                    timer_running,
	output logic                    pin1_is_output
);
	import tces_pkg::*;

	localparam int unsigned GAP_W = PULSE_W + 3;

	if (PULSE_W < 10) begin : g_chk
		$error("tces_host: PULSE_W must be at least 10");
	end

	typedef enum {
		ST_IDLE, ST_WRITE, ST_FIN, ST_RWAIT, ST_RCAP
	} tces_state_e;

	typedef struct packed {
		tces_state_e           st;
		logic [1:0]            idx;
		logic [1:0]            n;
		logic [2:0][15:0]      q_addr;
		logic [2:0][7:0]       q_data;
		logic [7:0]            dir;
		logic [7:0]            ana;
		logic [7:0]            latch;
		logic [7:0]            toc;
		logic [7:0]            prm;
		logic                  running;
		logic                  pin1_out;
		logic [GAP_W-1:0]      gap;
		tces_bus_s             bus;
		tces_rsp_s             rsp;
		logic [PULSE_W-1:0]    pcnt;
		logic [1:0]            pins;
		logic [1:0]            osync;
	} tces_st_s;

	tces_st_s st_r;
	tces_st_s st_nxt;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [PULSE_W-1:0] half_eff(input logic [PULSE_W-1:0] h);
		// external pulses must stay longer than two peripheral periods
		// minimum pulse width
		half_eff = (h < PULSE_W'(PULSE_MIN_CYC)) ? PULSE_W'(PULSE_MIN_CYC) : h;
	endfunction : half_eff

	function automatic logic [GAP_W-1:0] gap_cycles(input logic [1:0] sel, input logic [PULSE_W-1:0] h);
		case (sel)
			2'h0:    gap_cycles = GAP_W'(GAP_PERIODS * FXP_CYC);
			2'h1:    gap_cycles = GAP_W'(GAP_PERIODS * FXP_CYC * DIV_SEL1);
			2'h2:    gap_cycles = GAP_W'(GAP_PERIODS * FXP_CYC * DIV_SEL2);
			default: gap_cycles = GAP_W'({half_eff(h), 2'b00});
		endcase
	endfunction : gap_cycles

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.bus.wr = 1'b0;
		st_nxt.bus.rd = 1'b0;
		st_nxt.rsp.done = 1'b0;
		st_nxt.rsp.err = 1'b0;
		if (st_r.gap != '0)
		begin
			st_nxt.gap = st_r.gap - GAP_W'(1);
		end
		// device output pin passes two flops first
		st_nxt.osync = {st_r.osync[0], timer_output_pin};

		// pulse source on the timer input pins
		if (pulse_en == 2'b00)
		begin
			st_nxt.pcnt = '0;
		end
		else if (st_r.pcnt >= half_eff(pulse_half) - PULSE_W'(1))
		begin
			st_nxt.pcnt = '0;
			st_nxt.pins = st_r.pins ^ pulse_en;
		end
		else
		begin
			st_nxt.pcnt = st_r.pcnt + PULSE_W'(1);
		end

		case (st_r.st)
			ST_IDLE:
			begin
				if (cmd_valid && cmd_ready)
				begin
					st_nxt.n = 2'd1;
					st_nxt.q_addr[0] = ADDR_MODE_CTRL;
					st_nxt.q_data[0] = MODE_STOP;
					st_nxt.st = ST_WRITE;
					case (cmd.op)
						OP_CFG_IN:
						begin
							st_nxt.dir[PIN0] = 1'b1;
							st_nxt.dir[PIN1] = 1'b1;
							st_nxt.ana[PIN0] = 1'b0;
							st_nxt.ana[PIN1] = 1'b0;
							st_nxt.pin1_out = 1'b0;
							st_nxt.q_addr[0] = ADDR_PORT2_DIR;
							st_nxt.q_data[0] = st_nxt.dir;
							st_nxt.q_addr[1] = ADDR_PORT2_ANA;
							st_nxt.q_data[1] = st_nxt.ana;
							st_nxt.n = 2'd2;
						end
						OP_CFG_OUT:
						begin
							st_nxt.latch[PIN1] = 1'b0;
							st_nxt.dir[PIN1] = 1'b0;
							st_nxt.ana[PIN1] = 1'b0;
							st_nxt.pin1_out = 1'b1;
							st_nxt.q_addr[0] = ADDR_PORT2_LATCH;
							st_nxt.q_data[0] = st_nxt.latch;
							st_nxt.q_addr[1] = ADDR_PORT2_DIR;
							st_nxt.q_data[1] = st_nxt.dir;
							st_nxt.q_addr[2] = ADDR_PORT2_ANA;
							st_nxt.q_data[2] = st_nxt.ana;
							st_nxt.n = 2'd3;
						end
						OP_SET_CLK:
						begin
							if (cmd.data[IN1_ES_LSB +: 2] == EDGE_PROHIB ||
								cmd.data[IN0_ES_LSB +: 2] == EDGE_PROHIB)
							begin
								st_nxt.st = ST_FIN;
								st_nxt.rsp.err = 1'b1;
							end
							else
							begin
								st_nxt.running = 1'b0;
								st_nxt.prm = cmd.data & ~PRM_RSVD;
								st_nxt.q_addr[1] = ADDR_CLK_EDGE;
								st_nxt.q_data[1] = st_nxt.prm;
								st_nxt.n = 2'd2;
							end
						end
						OP_START:
						begin
							if (st_r.prm[CLKSEL_LSB +: 2] == CLKSEL_IN0 &&
								cmd.data[MODE_CS_LSB +: 2] == MODE_CS_EDGE)
							begin
								st_nxt.st = ST_FIN;
								st_nxt.rsp.err = 1'b1;
							end
							else
							begin
								st_nxt.running = 1'b1;
								st_nxt.q_data[0] = cmd.data;
							end
						end
						OP_STOP:
						begin
							st_nxt.running = 1'b0;
						end
						OP_OUT_CTL:
						begin
							if (cmd.data[TOC_SET] && cmd.data[TOC_CLR])
							begin
								st_nxt.st = ST_FIN;
								st_nxt.rsp.err = 1'b1;
							end
							else
							begin
								st_nxt.running = 1'b0;
								st_nxt.q_addr[1] = ADDR_OUT_CTRL;
								st_nxt.q_data[1] = cmd.data & ~(8'h01 << TOC_TRIG);
								st_nxt.toc = st_nxt.q_data[1] & ~((8'h01 << TOC_SET) | (8'h01 << TOC_CLR));
								st_nxt.n = 2'd2;
							end
						end
						OP_TRIGGER:
						begin
							if (!st_r.toc[TOC_OSPE])
							begin
								st_nxt.st = ST_FIN;
								st_nxt.rsp.err = 1'b1;
							end
							else
							begin
								st_nxt.q_addr[0] = ADDR_OUT_CTRL;
								st_nxt.q_data[0] = st_r.toc | (8'h01 << TOC_TRIG);
								st_nxt.gap = gap_cycles(st_r.prm[CLKSEL_LSB +: 2], pulse_half);
							end
						end
						default:
						begin
							st_nxt.bus.addr = ADDR_OUT_CTRL;
							st_nxt.bus.rd = 1'b1;
							st_nxt.st = ST_RWAIT;
						end
					endcase
					st_nxt.idx = 2'd0;
				end
			end
			ST_WRITE:
			begin
				st_nxt.bus.addr = st_r.q_addr[st_r.idx];
				st_nxt.bus.wdata = st_r.q_data[st_r.idx];
				st_nxt.bus.wr = 1'b1;
				st_nxt.idx = st_r.idx + 2'd1;
				if (st_r.idx == st_r.n - 2'd1)
				begin
					st_nxt.st = ST_FIN;
				end
			end
			ST_FIN:
			begin
				st_nxt.rsp.done = 1'b1;
				st_nxt.rsp.err = st_r.rsp.err;
				st_nxt.st = ST_IDLE;
			end
			ST_RWAIT:
			begin
				st_nxt.st = ST_RCAP;
			end
			ST_RCAP:
			begin
				st_nxt.rsp.rdata = dev_rdata;
				st_nxt.rsp.err = |(dev_rdata & ((8'h01 << TOC_TRIG) | (8'h01 << TOC_SET) | (8'h01 << TOC_CLR)));
				st_nxt.rsp.done = 1'b1;
				st_nxt.st = ST_IDLE;
			end
			default:
			begin
				st_nxt.st = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_r <= '0;
			st_r.st <= ST_IDLE;
			st_r.dir <= RST_DIR;
			st_r.ana <= RST_ANA;
			st_r.latch <= RST_LATCH;
			st_r.toc <= RST_OUT_CTRL;
			st_r.prm <= RST_CLK_EDGE;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign cmd_ready      = (st_r.st == ST_IDLE) && !(cmd.op == OP_TRIGGER && st_r.gap != '0);
	assign rsp            = st_r.rsp;
	assign dev_bus        = st_r.bus;
	assign timer_input0   = st_r.pins[PIN0];
	assign timer_input1   = st_r.pins[PIN1];
	assign out_level      = st_r.osync[1];
	assign timer_running  = st_r.running;
	assign pin1_is_output = st_r.pin1_out;
endmodule : tces_host
`default_nettype wire

// file: sim/tces_checker.sv
// checker: device bus and pin timing of the timer front-end controller
`default_nettype none
module tces_checker (
	input wire logic                clk,
	input wire logic                srst,
	input wire tces_pkg::tces_bus_s dev_bus,
	input wire tces_pkg::tces_rsp_s rsp,
	input wire logic                timer_input0
);
	import tces_pkg::*;
	logic wr_oc;
	logic wr_ce;
	logic wr_md;
	logic wr_dir;
	logic wr_tr;
	logic wr_lt;
	assign wr_lt = dev_bus.wr && dev_bus.addr == ADDR_PORT2_LATCH && !dev_bus.wdata[PIN1];
	assign wr_oc = dev_bus.wr && dev_bus.addr == ADDR_OUT_CTRL;
	assign wr_ce = dev_bus.wr && dev_bus.addr == ADDR_CLK_EDGE;
	assign wr_md = dev_bus.wr && dev_bus.addr == ADDR_MODE_CTRL && dev_bus.wdata == MODE_STOP;
	assign wr_dir = dev_bus.wr && dev_bus.addr == ADDR_PORT2_DIR;
	assign wr_tr = wr_oc && dev_bus.wdata[TOC_TRIG];
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	chk_edge_code: assert property (
		wr_ce |-> (dev_bus.wdata & PRM_RSVD) == 8'h00 && dev_bus.wdata[7:6] != EDGE_PROHIB
			&& dev_bus.wdata[5:4] != EDGE_PROHIB) else $error("bad clock edge write");
	chk_stop_first: assert property (
		wr_ce |-> $past(wr_md)) else $error("clock edge written while running");
	chk_oc_stopped: assert property (
		wr_oc && !dev_bus.wdata[TOC_TRIG] |-> $past(wr_md)) else $error("output control written while running");
	chk_trig_mode: assert property (
		wr_tr |-> dev_bus.wdata[TOC_OSPE]) else $error("trigger outside one-shot mode");
	chk_req_pair: assert property (
		wr_oc |-> dev_bus.wdata[3:2] != 2'b11) else $error("set and clear requested together");
	chk_trig_gap: assert property (
		wr_tr |=> (!wr_tr) [*7]) else $error("triggers too close");
	chk_pulse_min: assert property (
		$changed(timer_input0) |=> $stable(timer_input0) [*8]) else $error("input pulse too short");
	chk_in_role: assert property (
		wr_dir && dev_bus.wdata[PIN1] |=> dev_bus.wr && dev_bus.addr == ADDR_PORT2_ANA
			&& dev_bus.wdata[1:0] == 2'b00) else $error("input setup wrong");
	chk_out_role: assert property (
		wr_dir && !dev_bus.wdata[PIN1] |-> $past(wr_lt)) else $error("output latch not cleared");
	cover property (wr_tr);
	cover property (wr_ce);
	cover property (rsp.done && rsp.err);
endmodule : tces_checker
bind tces_host tces_checker tces_checker_i (.clk(clk), .srst(srst), .dev_bus(dev_bus), .rsp(rsp),
	.timer_input0(timer_input0));
`default_nettype wire

// file: sim/tces_dev.sv
// partner model: device registers and timer output
`default_nettype none
module tces_dev (
	input wire logic                clk,
	input wire logic                srst,
	input wire tces_pkg::tces_bus_s dev_bus,
	input wire logic [1:0]          timer_input_n,
	output logic [7:0]              dev_rdata,
	output logic                    timer_output_pin
);
	import tces_pkg::*;
	logic [7:0] dir_r, ana_r, latch_r, prm_r, toc_r, mode_r;
	logic [7:0] rd_r;
	logic       ff_r;
	logic       rv_r;
	logic [1:0] smp0_r, smp1_r, lvl_r, held_r, stb_r, rise, fall;
	logic [1:0][7:0] edge_cnt_r;
	logic       running_m;
	function automatic logic edge_ok(input logic [1:0] sel, input logic r, input logic f);
		edge_ok = (sel == 2'h0 && f) || (sel == 2'h1 && r) || (sel == 2'h3 && (r || f));
	endfunction : edge_ok
	assign running_m = mode_r != MODE_STOP;
	// held level is low after reset and frozen while stopped
	assign rise = {2{running_m}} & lvl_r & ~held_r;
	assign fall = {2{running_m}} & ~lvl_r & held_r;
	// released read bus shows the inverse of the last value
	assign dev_rdata = rv_r ? rd_r : ~rd_r;
	assign timer_output_pin = toc_r[TOC_OE] & ff_r;
	always_ff @(posedge clk)
	begin
		rv_r <= dev_bus.rd && !srst;
		if (dev_bus.rd)
			rd_r <= (dev_bus.addr == ADDR_OUT_CTRL) ? toc_r : prm_r;
		if (srst)
		begin
			dir_r <= RST_DIR;
			ana_r <= RST_ANA;
			latch_r <= RST_LATCH;
			prm_r <= RST_CLK_EDGE;
			toc_r <= RST_OUT_CTRL;
			mode_r <= MODE_STOP;
			ff_r <= 1'b0;
			rd_r <= 8'h00;
		end
		else if (dev_bus.wr)
		begin
			case (dev_bus.addr)
				ADDR_PORT2_DIR: dir_r <= dev_bus.wdata | 8'hF0;
				ADDR_PORT2_ANA: ana_r <= dev_bus.wdata & 8'h0F;
				ADDR_PORT2_LATCH: latch_r <= dev_bus.wdata;
				ADDR_CLK_EDGE: prm_r <= dev_bus.wdata & ~PRM_RSVD;
				ADDR_MODE_CTRL: mode_r <= dev_bus.wdata;
				// requests act once and read zero
				ADDR_OUT_CTRL:
				begin
					toc_r <= dev_bus.wdata & 8'hB3;
					if (dev_bus.wdata[3:2] != 2'b00) ff_r <= dev_bus.wdata[3];
				end
				default: ;
			endcase
		end
	end
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			smp0_r <= 2'h0;
			smp1_r <= 2'h0;
			lvl_r <= 2'h0;
			held_r <= 2'h0;
			stb_r <= 2'h0;
			edge_cnt_r <= '0;
		end
		else
		begin
			smp0_r <= timer_input_n;
			smp1_r <= smp0_r;
			// a level counts once seen on two samples
			lvl_r <= (smp0_r & smp1_r) | (lvl_r & (smp0_r | smp1_r));
			if (running_m)
				held_r <= lvl_r;
			stb_r[0] <= edge_ok(prm_r[5:4], rise[0], fall[0]);
			stb_r[1] <= edge_ok(prm_r[7:6], rise[1], fall[1]);
			edge_cnt_r[0] <= edge_cnt_r[0] + {7'h00, stb_r[0]};
			edge_cnt_r[1] <= edge_cnt_r[1] + {7'h00, stb_r[1]};
		end
	end
endmodule : tces_dev
`default_nettype wire

// file: sim/tces_host_bench.sv
// testbench: command sequences against the device model
`default_nettype none
module tces_host_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import tces_pkg::*;
	logic clk = 0, srst = 1, cmd_valid = 0;
	tces_cmd_s cmd = '0;
	logic [1:0] pulse_en = 2'b00;
	logic [15:0] pulse_half = 16'h0003;
	tces_rsp_s rsp;
	tces_bus_s dev_bus;
	logic [7:0] rdata;
	logic ti0, ti1, top, lvl, running, p1out, ready;
	int bad_count = 0, compares = 0, n, gap_exp;
	logic [2:0] k;
	time t0, t1;
	always #12.5 clk = ~clk;
	tces_host tces_host_i (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(ready),
		.rsp(rsp), .dev_bus(dev_bus), .dev_rdata(rdata), .pulse_en(pulse_en), .pulse_half(pulse_half),
		.timer_input0(ti0), .timer_input1(ti1), .timer_output_pin(top), .out_level(lvl),
		.timer_running(running), .pin1_is_output(p1out));
	tces_dev tces_dev_i (.clk(clk), .srst(srst), .dev_bus(dev_bus), .timer_input_n({ti1, ti0}),
		.dev_rdata(rdata), .timer_output_pin(top));
	task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	task report_and_stop;
		$display("compares %0d bad %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	task run(input tces_op_e op, input logic [7:0] d, input logic e);
		n = 0;
		cmd_valid = 1;
		cmd = {op, d};
		@(posedge clk);
		while (!ready && n < 9000)
		begin
			@(posedge clk);
			n++;
		end
		t0 = $time;
		@(negedge clk);
		cmd_valid = 0;
		while (!rsp.done && n < 9000)
		begin
			@(negedge clk);
			n++;
		end
		check("done err", {rsp.done, rsp.err}, {1'b1, e});
	endtask : run
	initial
	begin
		#500000;
		bad_count++;
		report_and_stop;
	end
	initial
	begin
		repeat (10) @(negedge clk);
		srst = 0;
		check("reset dir ana", {tces_dev_i.dir_r, tces_dev_i.ana_r}, {RST_DIR, RST_ANA});
		run(OP_CFG_OUT, 8'h00, 0);
		check("out role", {p1out, tces_dev_i.dir_r[1], tces_dev_i.ana_r[1], tces_dev_i.latch_r[1]}, 4'h8);
		run(OP_CFG_IN, 8'h00, 0);
		check("in role", {p1out, tces_dev_i.dir_r[1:0], tces_dev_i.ana_r[1:0]}, 5'h0C);
		for (k = 0; k < 4; k++)
		begin
			run(OP_SET_CLK, {k[1:0], k[1:0], 2'b11, k[1:0]}, k == 2);
			if (k != 2) check("prm", tces_dev_i.prm_r, {k[1:0], k[1:0], 2'b00, k[1:0]});
		end
		run(OP_START, 8'h08, 1);
		run(OP_START, 8'h04, 0);
		check("start", {running, tces_dev_i.mode_r}, 9'h104);
		pulse_en = 2'b11;
		@(posedge ti0);
		n = 0;
		while (ti0 && n < 50)
		begin
			@(negedge clk);
			n++;
			if (n == 1) check("pin1 high", ti1, 1);
		end
		check("pulse", n, PULSE_MIN_CYC + 1);
		pulse_en = 2'b00;
		repeat (8) @(negedge clk);
		check("edges running", tces_dev_i.edge_cnt_r, 16'h0202);
		run(OP_STOP, 8'h00, 0);
		check("stop", running, 0);
		pulse_en = 2'b11;
		@(posedge ti0);
		@(negedge clk);
		pulse_en = 2'b00;
		repeat (8) @(negedge clk);
		check("edges stopped", tces_dev_i.edge_cnt_r, 16'h0202);
		run(OP_START, 8'h04, 0);
		repeat (8) @(negedge clk);
		check("edges restart", tces_dev_i.edge_cnt_r, 16'h0303);
		run(OP_SET_CLK, 8'h00, 0);
		run(OP_OUT_CTL, 8'h0D, 1);
		run(OP_OUT_CTL, 8'h09, 0);
		repeat (4) @(negedge clk);
		check("level set", lvl, 1);
		run(OP_OUT_CTL, 8'h05, 0);
		repeat (4) @(negedge clk);
		check("level clear", lvl, 0);
		run(OP_TRIGGER, 8'h00, 1);
		run(OP_OUT_CTL, 8'h21, 0);
		for (k = 0; k < 4; k++)
		begin
			run(OP_SET_CLK, {6'h00, k[1:0]}, 0);
			gap_exp = (k == 3) ? 2 * GAP_PERIODS * PULSE_MIN_CYC
				: GAP_PERIODS * FXP_CYC * ((k == 1) ? DIV_SEL1 : (k == 2) ? DIV_SEL2 : 1);
			run(OP_TRIGGER, 8'h00, 0);
			t1 = t0;
			run(OP_TRIGGER, 8'h00, 0);
			check("gap", (t0 - t1) >= gap_exp * 25, 1);
		end
		run(OP_CHECK, 8'h00, 0);
		check("readback", rsp.rdata, 8'h21);
		report_and_stop;
	end
endmodule : tces_host_bench
`default_nettype wire
